// *** logic/pcc_top.sv ***
`timescale 1ns/100ps
`include "pcc_defines.svh"
module pcc_top
  import pcc_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // Parameter access
  input  wire pcc_bus_t            bus_i,
  output logic              [15:0] rdata_o,
  output logic                     rvalid_o,
  // Actual position and comparison values
  input  wire logic signed  [31:0] pos_i,
  input  wire pcc_cmp_t      [3:0] cmp_i,
  // Channel status
  output logic               [3:0] status_o
);

  pcc_state_t q;
  pcc_state_t next_q;

  // ==========================================================
  // Criterion evaluation
  function automatic logic crit_met(input pcc_crit_t c, input logic signed [31:0] p,
                                    input pcc_cmp_t v);
    logic inside_ab;
    inside_ab = (p >= v.val_a) && (p <= v.val_b);
    unique case (c)
      PCC_CRIT_GE:      crit_met = (p >= v.val_a);
      PCC_CRIT_LE:      crit_met = (p <= v.val_a);
      PCC_CRIT_IN_BAS,
      PCC_CRIT_IN_EXT:  crit_met = inside_ab;
      PCC_CRIT_OUT_BAS,
      PCC_CRIT_OUT_EXT: crit_met = (p < v.val_a) || (p > v.val_b);
      default:          crit_met = 1'b0;
    endcase
  endfunction

  // Criterion select address of one channel
  function automatic logic is_crit_addr(input logic [11:0] a, input int idx);
    is_crit_addr = (a == (`PCC_OFS_CRIT1 + 12'(`PCC_ADDR_STRIDE * idx)));
  endfunction

  // Run value inside the accepted range
  function automatic logic run_ok(input logic [15:0] w);
    run_ok = (w <= `PCC_RUN_MAX);
  endfunction

  // Criterion value inside the accepted range
  function automatic logic crit_ok(input logic [15:0] w);
    crit_ok = (w <= `PCC_CRIT_MAX);
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_q        = q;
    next_q.rvalid = 1'b0;
    if (bus_i.wr) begin
      for (int i = 0; i < `PCC_NUM_CH; i++) begin
        if (is_crit_addr(bus_i.addr, i) && crit_ok(bus_i.wdata)) begin
          next_q.crit[i] = pcc_crit_t'(bus_i.wdata[2:0]);
        end
      end
      unique case (bus_i.addr)
        `PCC_OFS_CH1_RUN: begin
          if (run_ok(bus_i.wdata)) begin
            next_q.run[0] = pcc_run_t'(bus_i.wdata[1:0]);
          end
        end
        `PCC_OFS_CH2_RUN: begin
          if (run_ok(bus_i.wdata)) begin
            next_q.run[1] = pcc_run_t'(bus_i.wdata[1:0]);
          end
        end
        `PCC_OFS_CH3_RUN: begin
          if (run_ok(bus_i.wdata)) begin
            next_q.run[2] = pcc_run_t'(bus_i.wdata[1:0]);
          end
        end
        `PCC_OFS_CH4_RUN: begin
          if (run_ok(bus_i.wdata)) begin
            next_q.run[3] = pcc_run_t'(bus_i.wdata[1:0]);
          end
        end
        `PCC_OFS_GROUP_RUN: begin
          if (bus_i.wdata <= `PCC_GROUP_MAX) begin
            next_q.group = bus_i.wdata[3:0];
            for (int i = 0; i < `PCC_NUM_CH; i++) begin
              next_q.run[i] = bus_i.wdata[i] ? PCC_RUN_ON : PCC_RUN_HOLD;
            end
          end
        end
        default: ;
      endcase
    end
    // Status acts on the run control as it stands after this cycle's write, and on the criterion as registered before it
    for (int i = 0; i < `PCC_NUM_CH; i++) begin
      unique case (next_q.run[i])
        PCC_RUN_HOLD: next_q.status[i] = q.status[i];
        PCC_RUN_ON:   next_q.status[i] = crit_met(q.crit[i], pos_i, cmp_i[i]);
        PCC_RUN_CLR:  next_q.status[i] = 1'b0;
        PCC_RUN_SET:  next_q.status[i] = 1'b1;
      endcase
    end
    if (bus_i.rd) begin
      next_q.rvalid = 1'b1;
      next_q.rdata  = 16'h0000;
      for (int i = 0; i < `PCC_NUM_CH; i++) begin
        if (is_crit_addr(bus_i.addr, i)) begin
          next_q.rdata = {13'h0, q.crit[i]};
        end
      end
      unique case (bus_i.addr)
        `PCC_OFS_CH1_RUN:   next_q.rdata = {14'h0, q.run[0]};
        `PCC_OFS_CH2_RUN:   next_q.rdata = {14'h0, q.run[1]};
        `PCC_OFS_CH3_RUN:   next_q.rdata = {14'h0, q.run[2]};
        `PCC_OFS_CH4_RUN:   next_q.rdata = {14'h0, q.run[3]};
        `PCC_OFS_GROUP_RUN: next_q.rdata = {12'h000, q.group};
        `PCC_OFS_STATUS:    next_q.rdata = {12'h000, q.status};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o  = q.rdata;
  assign rvalid_o = q.rvalid;
  assign status_o = q.status;

  // ==========================================================
  // Checks
  hold_state_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[0] == PCC_RUN_HOLD) |=> $stable(status_o[0]))
    else $error("Held status changed");
  hold_ch2_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[1] == PCC_RUN_HOLD) |=> $stable(status_o[1]))
    else $error("Held status changed");
  hold_ch3_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[2] == PCC_RUN_HOLD) |=> $stable(status_o[2]))
    else $error("Held status changed");
  hold_ch4_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[3] == PCC_RUN_HOLD) |=> $stable(status_o[3]))
    else $error("Held status changed");
  run_ch1_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[0] == PCC_RUN_ON) |=> status_o[0] == $past(crit_met(q.crit[0], pos_i, cmp_i[0])))
    else $error("Running status wrong");
  run_follow_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[1] == PCC_RUN_ON) |=> status_o[1] == $past(crit_met(q.crit[1], pos_i, cmp_i[1])))
    else $error("Running status wrong");
  run_ch3_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[2] == PCC_RUN_ON) |=> status_o[2] == $past(crit_met(q.crit[2], pos_i, cmp_i[2])))
    else $error("Running status wrong");
  run_ch4_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (next_q.run[3] == PCC_RUN_ON) |=> status_o[3] == $past(crit_met(q.crit[3], pos_i, cmp_i[3])))
    else $error("Running status wrong");
  clear_ch1_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[0] == PCC_RUN_CLR) |-> !status_o[0])
    else $error("Forced zero missing");
  clear_ch2_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[1] == PCC_RUN_CLR) |-> !status_o[1])
    else $error("Forced zero missing");
  force_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[2] == PCC_RUN_CLR) |-> !status_o[2])
    else $error("Forced zero missing");
  clear_ch4_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[3] == PCC_RUN_CLR) |-> !status_o[3])
    else $error("Forced zero missing");
  set_ch1_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[0] == PCC_RUN_SET) |-> status_o[0])
    else $error("Forced one missing");
  set_ch2_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[1] == PCC_RUN_SET) |-> status_o[1])
    else $error("Forced one missing");
  set_ch3_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[2] == PCC_RUN_SET) |-> status_o[2])
    else $error("Forced one missing");
  force_one_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (q.run[3] == PCC_RUN_SET) |-> status_o[3])
    else $error("Forced one missing");

  // ==========================================================
  // Checks: register writes
  write_now_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CH1_RUN && bus_i.wdata == 16'(PCC_RUN_SET)) |=> status_o[0])
    else $error("Write not immediate");
  run_take_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CH3_RUN && run_ok(bus_i.wdata)) |=> q.run[2] == $past(bus_i.wdata[1:0]))
    else $error("Run value not taken");
  run_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CH2_RUN && bus_i.wdata > `PCC_RUN_MAX) |=> $stable(q.run[1]))
    else $error("Bad run value taken");
  run_range_ch4_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CH4_RUN && !run_ok(bus_i.wdata)) |=> $stable(q.run[3]))
    else $error("Bad run value taken");
  crit_take_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CRIT1 && crit_ok(bus_i.wdata)) |=> q.crit[0] == $past(bus_i.wdata[2:0]))
    else $error("Criterion not taken");
  crit_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_CRIT1 && !crit_ok(bus_i.wdata)) |=> $stable(q.crit[0]))
    else $error("Bad criterion taken");
  group_take_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_GROUP_RUN && bus_i.wdata <= `PCC_GROUP_MAX)
    |=> q.group == $past(bus_i.wdata[3:0]))
    else $error("Group value not taken");
  group_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_GROUP_RUN && bus_i.wdata > `PCC_GROUP_MAX)
    |=> $stable(q.group) && $stable(q.run))
    else $error("Bad group value taken");
  group_ch1_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_GROUP_RUN && bus_i.wdata <= `PCC_GROUP_MAX)
    |=> q.run[0] == ($past(bus_i.wdata[0]) ? PCC_RUN_ON : PCC_RUN_HOLD))
    else $error("Group mask decode wrong");
  group_map_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_GROUP_RUN && bus_i.wdata <= `PCC_GROUP_MAX)
    |=> q.run[2] == ($past(bus_i.wdata[2]) ? PCC_RUN_ON : PCC_RUN_HOLD))
    else $error("Group mask decode wrong");
  group_ch4_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == `PCC_OFS_GROUP_RUN && bus_i.wdata <= `PCC_GROUP_MAX)
    |=> q.run[3] == ($past(bus_i.wdata[3]) ? PCC_RUN_ON : PCC_RUN_HOLD))
    else $error("Group mask decode wrong");

  // ==========================================================
  // Checks: register reads
  run_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.rd && bus_i.addr == `PCC_OFS_CH4_RUN) |=> rdata_o == {14'h0, $past(q.run[3])})
    else $error("Run read wrong");
  status_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_i.rd && bus_i.addr == `PCC_OFS_STATUS) |=> rdata_o == {12'h000, $past(status_o)} && rvalid_o)
    else $error("Status read wrong");
  read_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bus_i.rd |=> rvalid_o)
    else $error("Read not answered");
  idle_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !bus_i.rd |=> !rvalid_o)
    else $error("Answer without read");

endmodule

// *** logic/pcc_defines.svh ***
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH
// Register byte offsets
`define PCC_OFS_CH1_RUN   12'hb04
`define PCC_OFS_CH2_RUN   12'hb06
`define PCC_OFS_CH3_RUN   12'hb18
`define PCC_OFS_CH4_RUN   12'hb1a
`define PCC_OFS_GROUP_RUN 12'hb2c
`define PCC_OFS_STATUS    12'hb30
`define PCC_OFS_CRIT1     12'hb40
// Spacing between per-channel criterion selects
`define PCC_ADDR_STRIDE   12'h002
// Limits and resets
`define PCC_RUN_MAX       16'h0003
`define PCC_GROUP_MAX     16'h000f
`define PCC_CRIT_MAX      16'h0005
`define PCC_RST_VAL       16'h0000
`define PCC_NUM_CH        4
`endif

// *** logic/pcc_pkg.sv ***
package pcc_pkg;
  typedef enum logic [1:0] {
    PCC_RUN_HOLD = 2'b00,
    PCC_RUN_ON   = 2'b01,
    PCC_RUN_CLR  = 2'b10,
    PCC_RUN_SET  = 2'b11
  } pcc_run_t;

  typedef enum logic [2:0] {
    PCC_CRIT_GE      = 3'b000,
    PCC_CRIT_LE      = 3'b001,
    PCC_CRIT_IN_BAS  = 3'b010,
    PCC_CRIT_OUT_BAS = 3'b011,
    PCC_CRIT_IN_EXT  = 3'b100,
    PCC_CRIT_OUT_EXT = 3'b101
  } pcc_crit_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } pcc_bus_t;

  typedef struct packed {
    logic signed [31:0] val_a;
    logic signed [31:0] val_b;
  } pcc_cmp_t;

  typedef struct packed {
    pcc_run_t  [3:0] run;
    pcc_crit_t [3:0] crit;
    logic      [3:0] group;
    logic      [3:0] status;
    logic     [15:0] rdata;
    logic            rvalid;
  } pcc_state_t;
endpackage

// *** dv/pcc_tb.sv ***
`timescale 1ns/100ps
// ==========
// Bench
module testbench
  import pcc_pkg::*;
;
  logic                      sys_clk_i   = 1'b0;
  logic                      rst_i       = 1'b1;
  pcc_bus_t                  bus_i       = '0;
  logic signed        [31:0] pos_i       = '0;
  pcc_cmp_t            [3:0] cmp_i       = '0;
  logic               [15:0] rdata_o;
  logic                      rvalid_o;
  logic                [3:0] status_o;
  int                        failures    = 0;
  int                        checks_done = 0;
  int                        cycles      = 0;
  logic               [11:0] ofs [4]     = '{12'hb04, 12'hb06, 12'hb18, 12'hb1a};
  logic signed        [31:0] pv [3]      = '{32'sh0c8, 32'sh064, 32'sh032};
  logic                [5:0] ex [3]      = '{6'h15, 6'h17, 6'h2a};
  logic               [15:0] gv [4]      = '{16'h0005, 16'h0009, 16'h0006, 16'h0000};
  logic               [15:0] sv [4]      = '{16'h0005, 16'h000d, 16'h000f, 16'h000f};

  always #5 sys_clk_i = ~sys_clk_i;

  pcc_top DUT (
    .sys_clk_i(sys_clk_i),
    .rst_i    (rst_i),
    .bus_i    (bus_i),
    .rdata_o  (rdata_o),
    .rvalid_o (rvalid_o),
    .pos_i    (pos_i),
    .cmp_i    (cmp_i),
    .status_o (status_o)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    bus_i <= '0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    bus_i <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk_i);
    bus_i <= '0;
    #1;
    check({15'h0000, rvalid_o}, 16'h0001);
    check(rdata_o, e);
  endtask

  task automatic reset_and_check();
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    check({12'h000, status_o}, 16'h0000);
    for (int i = 0; i < 4; i++) rd(ofs[i], 16'h0000);
    rd(12'hb2c, 16'h0000);
    rd(12'hb40, 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  // ==========
  // Tests
  initial begin
    reset_and_check();
    rd(12'hb00, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 16'h0003);
      check({12'h000, status_o}, 16'h0001 << i);
      wr(ofs[i], 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      #1;
      check({12'h000, status_o}, 16'h0001 << i);
      wr(ofs[i], 16'h0002);
      check({12'h000, status_o}, 16'h0000);
      wr(ofs[i], 16'h0004);
      rd(ofs[i], 16'h0002);
      wr(ofs[i], 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      #1;
      check({12'h000, status_o}, 16'h0000);
    end
    $display("test forced states done");
    wr(12'hb04, 16'h0001);
    for (int p = 0; p < 3; p++) begin
      @(posedge sys_clk_i);
      cmp_i[0] <= '{32'sh064, 32'sh12c};
      pos_i <= pv[p];
      for (int c = 0; c < 6; c++) begin
        wr(12'hb40, c[15:0]);
        @(posedge sys_clk_i);
        #1;
        check({15'h0000, status_o[0]}, {15'h0000, ex[p][c]});
      end
    end
    rd(12'hb30, 16'h0001);
    wr(12'hb40, 16'h0006);
    rd(12'hb40, 16'h0005);
    $display("test running done");
    wr(12'hb2c, 16'h0015);
    rd(12'hb2c, 16'h0000);
    rd(ofs[2], 16'h0000);
    foreach (gv[k]) begin
      wr(12'hb2c, gv[k]);
      rd(12'hb2c, gv[k]);
      for (int i = 0; i < 4; i++) rd(ofs[i], {15'h0000, gv[k][i]});
      rd(12'hb30, sv[k]);
    end
    $display("test group done");
    @(posedge sys_clk_i);
    reset_and_check();
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
